/* verilog/opdec_defines.vh */
/*
 * opcode patterns, field positions and cycle counts for the load, multiply,
 * normalize and OR decoder.
 * assumes inclusion by bare name from the decoder files.
 */
`ifndef OPDEC_DEFINES_VH
`define OPDEC_DEFINES_VH

// high-byte opcodes (bits 15:8)
`define OP_LD_ACC_SHORT    8'hB9
`define OP_LD_HIGH_ACC     8'h6A
`define OP_LD_LOW_ACC      8'h69
`define OP_LD_ACC_OPSHIFT  8'h6B
`define OP_LD_PAGE_MEM     8'h0D
`define OP_LD_STATUS0      8'h0E
`define OP_LD_STATUS1      8'h0F
`define OP_LT_ACCUM        8'h70
`define OP_LT_MOVE         8'h72
`define OP_LT_TRANSFER     8'h71
`define OP_LT_SUBTRACT     8'h74
`define OP_MAC_MOVE        8'hA3
`define OP_MULTIPLY        8'h54
`define OP_MULTIPLY_ADD    8'h50
`define OP_MULTIPLY_SUB    8'h51
`define OP_NORMALIZE       8'hA0
// partial patterns
`define OP_AUX_SHORT_HI5   5'h16
`define OP_PAGE_IMM_HI7    7'h5E
`define OP_AUX_LONG_HI13   13'h17E1
`define OP_AUX_PTR_HI13    13'h1171
`define OP_OR_SHIFT_HI12   12'hBFC
// full words
`define OP_OR_SHIFT16      16'hBE82
`define OP_PROD_TO_ACC     16'hBE03

// operation codes on op_code_out
`define OPC_NONE           5'h00
`define OPC_LD_ACC_SHORT   5'h01
`define OPC_LD_HIGH_ACC    5'h02
`define OPC_LD_LOW_ACC     5'h03
`define OPC_LD_ACC_OPSHIFT 5'h04
`define OPC_LD_AUX_SHORT   5'h05
`define OPC_LD_AUX_LONG    5'h06
`define OPC_LD_PAGE_MEM    5'h07
`define OPC_LD_PAGE_IMM    5'h08
`define OPC_LD_STATUS0     5'h09
`define OPC_LD_STATUS1     5'h0A
`define OPC_LT_ACCUM       5'h0B
`define OPC_LT_MOVE        5'h0C
`define OPC_LT_TRANSFER    5'h0D
`define OPC_LT_SUBTRACT    5'h0E
`define OPC_MAC_MOVE       5'h0F
`define OPC_AUX_PTR        5'h10
`define OPC_MULTIPLY       5'h11
`define OPC_MULTIPLY_ADD   5'h12
`define OPC_MULTIPLY_SUB   5'h13
`define OPC_NORMALIZE      5'h14
`define OPC_OR_SHIFT       5'h15
`define OPC_OR_SHIFT16     5'h16
`define OPC_PROD_TO_ACC    5'h17
`define OPC_ILLEGAL        5'h1F

// field positions
`define FLD_AUX_SEL_LSB    0
`define FLD_AUX_SHORT_LSB  8
`define FLD_SHIFT_LSB      0

// cycle counts
`define CYC_ONE            2'd1
`define CYC_TWO            2'd2
`define CYC_THREE          2'd3

`endif

/* verilog/opcode_table.v */
/*
 * combinational lookup of a first instruction word: operation code,
 * word count, cycle count and operand fields.
 * assumes a registered 16-bit word at its input.
 */
`timescale 1ns/100ps
`default_nettype none
`include "opdec_defines.vh"
module opcode_table (
  input wire [15:0] word_in,
  output reg [4:0] op_out,
  output reg two_word_out,
  output reg [1:0] cycles_out,
  output reg [2:0] aux_sel_out,
  output reg [8:0] imm_out,
  output reg [3:0] shift_out
);
  always @* begin
    op_out = `OPC_ILLEGAL;
    two_word_out = 1'b0;
    cycles_out = `CYC_ONE;
    aux_sel_out = 3'h0;
    imm_out = {1'b0, word_in[7:0]};
    shift_out = 4'h0;
    if (word_in == `OP_OR_SHIFT16) begin
      op_out = `OPC_OR_SHIFT16;
      two_word_out = 1'b1;
      cycles_out = `CYC_TWO;
    end else if (word_in == `OP_PROD_TO_ACC) begin
      op_out = `OPC_PROD_TO_ACC;
    end else if (word_in[15:3] == `OP_AUX_LONG_HI13) begin
      op_out = `OPC_LD_AUX_LONG;
      two_word_out = 1'b1;
      cycles_out = `CYC_TWO;
      aux_sel_out = word_in[`FLD_AUX_SEL_LSB +: 3];
    end else if (word_in[15:3] == `OP_AUX_PTR_HI13) begin
      op_out = `OPC_AUX_PTR;
      aux_sel_out = word_in[`FLD_AUX_SEL_LSB +: 3];
    end else if (word_in[15:4] == `OP_OR_SHIFT_HI12) begin
      op_out = `OPC_OR_SHIFT;
      two_word_out = 1'b1;
      cycles_out = `CYC_TWO;
      shift_out = word_in[`FLD_SHIFT_LSB +: 4];
    end else if (word_in[15:9] == `OP_PAGE_IMM_HI7) begin
      op_out = `OPC_LD_PAGE_IMM;
      cycles_out = `CYC_TWO;
      imm_out = word_in[8:0];
    end else if (word_in[15:11] == `OP_AUX_SHORT_HI5) begin
      op_out = `OPC_LD_AUX_SHORT;
      cycles_out = `CYC_TWO;
      aux_sel_out = word_in[`FLD_AUX_SHORT_LSB +: 3];
    end else begin
      case (word_in[15:8])
        `OP_LD_ACC_SHORT: op_out = `OPC_LD_ACC_SHORT;
        `OP_LD_HIGH_ACC: op_out = `OPC_LD_HIGH_ACC;
        `OP_LD_LOW_ACC: op_out = `OPC_LD_LOW_ACC;
        `OP_LD_ACC_OPSHIFT: op_out = `OPC_LD_ACC_OPSHIFT;
        `OP_LD_PAGE_MEM: begin
          op_out = `OPC_LD_PAGE_MEM;
          cycles_out = `CYC_TWO;
        end
        `OP_LD_STATUS0: begin
          op_out = `OPC_LD_STATUS0;
          cycles_out = `CYC_TWO;
        end
        `OP_LD_STATUS1: begin
          op_out = `OPC_LD_STATUS1;
          cycles_out = `CYC_TWO;
        end
        `OP_LT_ACCUM: op_out = `OPC_LT_ACCUM;
        `OP_LT_MOVE: op_out = `OPC_LT_MOVE;
        `OP_LT_TRANSFER: op_out = `OPC_LT_TRANSFER;
        `OP_LT_SUBTRACT: op_out = `OPC_LT_SUBTRACT;
        `OP_MAC_MOVE: begin
          op_out = `OPC_MAC_MOVE;
          two_word_out = 1'b1;
          cycles_out = `CYC_THREE;
        end
        `OP_MULTIPLY: op_out = `OPC_MULTIPLY;
        `OP_MULTIPLY_ADD: op_out = `OPC_MULTIPLY_ADD;
        `OP_MULTIPLY_SUB: op_out = `OPC_MULTIPLY_SUB;
        `OP_NORMALIZE: op_out = `OPC_NORMALIZE;
        default: op_out = `OPC_ILLEGAL;
      endcase
    end
  end
endmodule // opcode_table
`default_nettype wire

/* verilog/cycle_counter.v */
/*
 * down counter that holds the decoder busy for the extra cycles of a
 * multi-cycle instruction.
 * assumes load_in is only raised while idle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "opdec_defines.vh"
module cycle_counter (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire load_in,
  input wire [1:0] count_in,
  output wire idle_out
);
  reg [1:0] left_r;
  reg [1:0] left_nxt;
  always @* begin
    left_nxt = left_r;
    if (load_in)
      left_nxt = count_in - `CYC_ONE;
    else if (left_r != 2'h0)
      left_nxt = left_r - `CYC_ONE;
  end
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      left_r <= 2'h0;
    else
      left_r <= left_nxt;
  end
  assign idle_out = (left_r == 2'h0);
endmodule // cycle_counter
`default_nettype wire

/* verilog/opcode_decoder.v */
/*
 * instruction decoder for accumulator, auxiliary, page, status and operand
 * loads, multiply variants, normalize, immediate OR and product transfer.
 * assumes program memory presents one word with word_valid_in and holds it
 * until word_ready_out; the datapath acts on a one-cycle exec_valid_out.
 */
// Summary of operation
// - high byte B9 loads accumulator with low-byte constant; zero clears.
// - high byte 6A zeroes low accumulator, loads high half from memory.
// - high byte 69 zeroes low accumulator, loads low without extension.
// - high byte 6B loads accumulator shifted by operand register amount.
// - 10110 plus aux select plus byte loads aux register, two cycles.
// - BF08 plus select, then constant word, loads aux register long.
// - 0D loads page from memory; 1011110 loads nine-bit page, two cycles.
// - 0E and 0F load first and second status words, two cycles each.
// - 70 loads operand register and adds previous product.
// - 72 as 70 and also moves data word to next address.
// - 71 loads operand register and transfers product to accumulator.
// - 74 loads operand register and subtracts previous product.
// - A3 plus program address word: multiply-accumulate with move, 3 cycles; the decoder stalls two cycles after the second word, 4 in all.
// - 8B88 plus select loads the aux register pointer, one cycle.
// - 54 multiplies data word by operand register into product.
// - 50 multiplies and adds previous product; 51 subtracts it.
// - A0 with address normalizes the accumulator, one cycle.
// - BFC plus shift, then constant, ORs shifted constant into accumulator.
// - BE82 then constant ORs constant shifted by sixteen into accumulator.
// - BE03 copies product register into accumulator, one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "opdec_defines.vh"
module opcode_decoder (
  input wire ref_clk_in,
  input wire rstn_in,
  input wire [15:0] word_in,
  input wire word_valid_in,
  output wire word_ready_out,
  output reg exec_valid_out,
  output reg [4:0] op_code_out,
  output reg [7:0] operand_address_field_out,
  output reg [15:0] constant_out,
  output reg [2:0] aux_register_select_out,
  output reg [3:0] shift_count_field_out,
  output reg [8:0] page_out,
  output reg illegal_out
);
  localparam ST_FIRST = 1'b0;
  localparam ST_SECOND = 1'b1;

  reg state_r;
  reg state_nxt;
  reg [15:0] first_r;
  reg [15:0] first_nxt;
  wire [4:0] tab_op;
  wire tab_two;
  wire [1:0] tab_cyc;
  wire [2:0] tab_aux;
  wire [8:0] tab_imm;
  wire [3:0] tab_shift;
  wire [15:0] look_word;
  wire idle;
  wire take;
  reg start_count;
  reg issue;

  // in the second state the table still looks at the held first word
  assign look_word = (state_r == ST_SECOND) ? first_r : word_in;

  opcode_table u_table (
    .word_in(look_word),
    .op_out(tab_op),
    .two_word_out(tab_two),
    .cycles_out(tab_cyc),
    .aux_sel_out(tab_aux),
    .imm_out(tab_imm),
    .shift_out(tab_shift)
  );

  cycle_counter u_count (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .load_in(start_count),
    .count_in(tab_cyc),
    .idle_out(idle)
  );

  // stalling fetch while busy keeps multi-cycle instructions from overlapping
  assign word_ready_out = idle;
  assign take = word_valid_in & idle;

  always @* begin
    state_nxt = state_r;
    first_nxt = first_r;
    start_count = 1'b0;
    issue = 1'b0;
    case (state_r)
      ST_FIRST: begin
        if (take) begin
          if (tab_two) begin
            first_nxt = word_in;
            state_nxt = ST_SECOND;
          end else begin
            issue = 1'b1;
            start_count = 1'b1;
          end
        end
      end
      ST_SECOND: begin
        // this word is operand data and bypasses the decoding path
        if (take) begin
          issue = 1'b1;
          state_nxt = ST_FIRST;
          // first cycle already spent fetching the first word
          start_count = (tab_cyc == `CYC_THREE);
        end
      end
      default: state_nxt = ST_FIRST;
    endcase
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_FIRST;
      first_r <= 16'h0000;
      exec_valid_out <= 1'b0;
      op_code_out <= `OPC_NONE;
      operand_address_field_out <= 8'h00;
      constant_out <= 16'h0000;
      aux_register_select_out <= 3'h0;
      shift_count_field_out <= 4'h0;
      page_out <= 9'h000;
      illegal_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      exec_valid_out <= issue;
      if (issue) begin
        op_code_out <= tab_op;
        illegal_out <= (tab_op == `OPC_ILLEGAL);
        operand_address_field_out <= look_word[7:0];
        aux_register_select_out <= tab_aux;
        shift_count_field_out <= tab_shift;
        page_out <= tab_imm;
        if (state_r == ST_SECOND)
          constant_out <= word_in;
        else
          constant_out <= {8'h00, look_word[7:0]};
      end
    end
  end
endmodule // opcode_decoder
`default_nettype wire

/* test/prog_mem_model.sv */
/* program memory model: offers queued words one at a time.
   assumes the decoder samples valid and ready at the rising edge. */
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
  input wire logic ref_clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [15:0] word_out
);
  logic [15:0] q [$];
  int gap = 0;
  int idle = 0;
  initial valid_out = 1'b0;
  initial word_out = 16'h0000;
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask
  always @(posedge ref_clk_in) begin
    if (valid_out && ready_in) begin
      void'(q.pop_front());
      idle = gap;
    end
    if (idle > 0 || q.size() == 0) begin
      // nothing offered: flip the bus so no stale word looks valid
      valid_out <= 1'b0;
      word_out <= ~word_out;
      if (idle > 0) idle--;
    end else begin
      valid_out <= 1'b1;
      word_out <= q[0];
    end
  end
endmodule // prog_mem_model
`default_nettype wire

/* test/opcode_decoder_sva.sv */
/* checker for the opcode decoder, watching its ports only.
   assumes it is bound to every instance of opcode_decoder. */
`timescale 1ns/100ps
`default_nettype none
`include "opdec_defines.vh"
module opcode_decoder_sva (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [15:0] word_in,
  input wire logic word_valid_in,
  input wire logic word_ready_out,
  input wire logic exec_valid_out,
  input wire logic [4:0] op_code_out,
  input wire logic [15:0] constant_out,
  input wire logic [2:0] aux_register_select_out,
  input wire logic illegal_out
);
  logic two_r;
  wire take = word_valid_in && word_ready_out;
  wire first = take && !two_r;
  // a first word that announces a constant or address word
  wire lead = word_in[15:3] == `OP_AUX_LONG_HI13 ||
    word_in[15:4] == `OP_OR_SHIFT_HI12 || word_in == `OP_OR_SHIFT16 ||
    word_in[15:8] == `OP_MAC_MOVE;
  always @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in) two_r <= 1'b0;
    else if (take) two_r <= !two_r && lead;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  acc_short_a:
  assert property (first && word_in[15:8] == `OP_LD_ACC_SHORT |=>
    exec_valid_out && op_code_out == `OPC_LD_ACC_SHORT &&
    constant_out == {8'h00, $past(word_in[7:0])}) else $error("short load");
  page_mem_a:
  assert property (first && word_in[15:8] == `OP_LD_PAGE_MEM |=>
    exec_valid_out && op_code_out == `OPC_LD_PAGE_MEM && !word_ready_out
    ##1 word_ready_out) else $error("page load timing");
  status_load_a:
  assert property (first && word_in[15:9] == 7'h07 |=> !word_ready_out &&
    op_code_out == ($past(word_in[8]) ? `OPC_LD_STATUS1 : `OPC_LD_STATUS0))
    else $error("status load");
  aux_short_a:
  assert property (first && word_in[15:11] == `OP_AUX_SHORT_HI5 |=>
    op_code_out == `OPC_LD_AUX_SHORT && !word_ready_out &&
    aux_register_select_out == $past(word_in[10:8])) else $error("aux short");
  lead_wait_a:
  assert property (first && lead |=> !exec_valid_out)
    else $error("first word issued alone");
  second_word_a:
  assert property (take && two_r |=> exec_valid_out && !illegal_out &&
    constant_out == $past(word_in)) else $error("second word");
  mac_stall_a:
  assert property (exec_valid_out && op_code_out == `OPC_MAC_MOVE |->
    !word_ready_out ##1 !word_ready_out ##1 word_ready_out)
    else $error("mac stall");
  prod_acc_a:
  assert property (first && word_in == `OP_PROD_TO_ACC |=> exec_valid_out &&
    op_code_out == `OPC_PROD_TO_ACC && word_ready_out) else $error("prod");
endmodule // opcode_decoder_sva
bind opcode_decoder opcode_decoder_sva i_sva (.ref_clk_in, .rstn_in,
  .word_in, .word_valid_in, .word_ready_out, .exec_valid_out, .op_code_out,
  .constant_out, .aux_register_select_out, .illegal_out);
`default_nettype wire

/* test/dsp_opcode_decode_load_mul_or_tb.sv */
/* testbench for the opcode decoder fed by a program memory model.
   assumes a 250 MHz clock and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "opdec_defines.vh"
module dsp_opcode_decode_load_mul_or_tb;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  wire [15:0] word;
  wire valid, ready, exec, ill;
  wire [4:0] op;
  wire [15:0] cst;
  wire [2:0] aux;
  wire [3:0] shf;
  wire [8:0] page;
  wire [7:0] addr;
  int err_total = 0;
  int cmp_count = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  prog_mem_model i_mem (.ref_clk_in, .ready_in(ready), .valid_out(valid),
    .word_out(word));
  opcode_decoder i_dut (.ref_clk_in, .rstn_in, .word_in(word),
    .word_valid_in(valid), .word_ready_out(ready), .exec_valid_out(exec),
    .op_code_out(op), .operand_address_field_out(addr), .constant_out(cst),
    .aux_register_select_out(aux), .shift_count_field_out(shf),
    .page_out(page), .illegal_out(ill));
  task automatic chk(input string nm, input logic [15:0] exp, got);
    cmp_count++;
    if (exp !== got) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_exec;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (exec !== 1'b1 && n < 40);
    chk("exec", 16'h0001, 16'(exec));
  endtask
  task automatic t_one_cycle;
    logic [15:0] w [14] = '{16'hB900, 16'h6A12, 16'h6934, 16'h6B56,
      16'h7078, 16'h729A, 16'h71BC, 16'h74DE, 16'h5401, 16'h5023,
      16'h5145, 16'hA067, 16'hBE03, 16'h8B8D};
    logic [4:0] o [14] = '{`OPC_LD_ACC_SHORT, `OPC_LD_HIGH_ACC,
      `OPC_LD_LOW_ACC, `OPC_LD_ACC_OPSHIFT, `OPC_LT_ACCUM, `OPC_LT_MOVE,
      `OPC_LT_TRANSFER, `OPC_LT_SUBTRACT, `OPC_MULTIPLY, `OPC_MULTIPLY_ADD,
      `OPC_MULTIPLY_SUB, `OPC_NORMALIZE, `OPC_PROD_TO_ACC, `OPC_AUX_PTR};
    foreach (w[i]) i_mem.put(w[i]);
    foreach (w[i]) begin
      wait_exec;
      chk("op", 16'(o[i]), 16'(op));
      chk("const", {8'h00, w[i][7:0]}, cst);
      chk("ready", 16'h0001, 16'(ready));
      chk("addr", {8'h00, w[i][7:0]}, 16'(addr));
      chk("illegal", 16'h0000, 16'(ill));
    end
    chk("aux", 16'h0005, 16'(aux));
  endtask
  task automatic t_two_cycle;
    logic [15:0] w [5] = '{16'h0D12, 16'hB1AB, 16'h0E01, 16'h0F02,
      16'hBDFF};
    logic [4:0] o [5] = '{`OPC_LD_PAGE_MEM, `OPC_LD_AUX_SHORT,
      `OPC_LD_STATUS0, `OPC_LD_STATUS1, `OPC_LD_PAGE_IMM};
    foreach (w[i]) i_mem.put(w[i]);
    foreach (w[i]) begin
      wait_exec;
      chk("op", 16'(o[i]), 16'(op));
      chk("busy", 16'h0000, 16'(ready));
      if (i == 1) chk("aux", 16'h0001, 16'(aux));
      if (i == 4) chk("page", 16'h01FF, 16'(page));
    end
  endtask
  task automatic t_two_word;
    // second words B905 and BE03 look like opcodes so a misread shows up
    logic [15:0] w [8] = '{16'hBF0D, 16'hB905, 16'hBFC5, 16'hABCD,
      16'hBE82, 16'h1234, 16'hA310, 16'hBE03};
    logic [4:0] o [4] = '{`OPC_LD_AUX_LONG, `OPC_OR_SHIFT, `OPC_OR_SHIFT16,
      `OPC_MAC_MOVE};
    i_mem.gap = 2;
    foreach (w[i]) i_mem.put(w[i]);
    foreach (o[i]) begin
      wait_exec;
      chk("op", 16'(o[i]), 16'(op));
      chk("const", w[2*i+1], cst);
      chk("addr", {8'h00, w[2*i][7:0]}, 16'(addr));
      if (i == 0) chk("aux", 16'h0005, 16'(aux));
      if (i == 1) chk("shift", 16'h0005, 16'(shf));
      if (i == 3) chk("busy", 16'h0000, 16'(ready));
    end
    i_mem.gap = 0;
  endtask
  task automatic t_unknown;
    i_mem.put(16'h0123);
    i_mem.put(16'hB9FF);
    wait_exec;
    chk("illegal", 16'h0001, 16'(ill));
    wait_exec;
    chk("op", 16'(`OPC_LD_ACC_SHORT), 16'(op));
    chk("const", 16'h00FF, cst);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_one_cycle();
    t_two_cycle();
    t_two_word();
    t_unknown();
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    err_total++;
    report_and_stop();
  end
endmodule // dsp_opcode_decode_load_mul_or_tb
`default_nettype wire
